// >>> regen_pkg.sv
package regen_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_LEVEL     = 8'h04;
    localparam logic [7:0] OFS_SENS      = 8'h08;
    localparam logic [7:0] OFS_LIMIT     = 8'h0c;
    localparam logic [7:0] OFS_VGAIN     = 8'h10;
    localparam logic [7:0] OFS_FGAIN     = 8'h14;
    localparam logic [7:0] OFS_MAXF      = 8'h18;
    localparam logic [7:0] OFS_STATE     = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h28;
    localparam logic [7:0] OFS_COMP      = 8'h2c;
    // reset values and accepted ranges (volts, percent, 0.1 Hz)
    localparam logic [1:0]  MODE_RST     = 2'h0;
    localparam logic [1:0]  MODE_MAX     = 2'h2;
    localparam logic [9:0]  LEVEL_MIN    = 10'h12c;
    localparam logic [9:0]  LEVEL_MAX    = 10'h320;
    localparam logic [2:0]  SENS_RST     = 3'h0;
    localparam logic [2:0]  SENS_MAX     = 3'h5;
    localparam logic [15:0] LIMIT_RST    = 16'h003c;
    localparam logic [15:0] LIMIT_MAX    = 16'h0064;
    localparam logic [15:0] LIMIT_OFF    = 16'h270f;
    localparam logic [7:0]  GAIN_RST     = 8'h64;
    localparam logic [7:0]  GAIN_MAX     = 8'hc8;
    localparam int          GAIN_SHIFT   = 13;
    localparam logic [15:0] COMP_DECAY   = 16'h0001;
    // rate thresholds in volts per sample, sensitivity 1 to 5
    localparam logic [9:0]  RATE_TH1     = 10'h014;
    localparam logic [9:0]  RATE_TH2     = 10'h010;
    localparam logic [9:0]  RATE_TH3     = 10'h00c;
    localparam logic [9:0]  RATE_TH4     = 10'h008;
    localparam logic [9:0]  RATE_TH5     = 10'h004;
    // irq bits
    localparam int IRQ_ACT   = 0;
    localparam int IRQ_RATE  = 1;
    localparam int IRQ_LIMIT = 2;
    localparam int IRQ_W     = 3;

    typedef enum logic [1:0] {
        OP_STOP  = 2'b00,
        OP_ACCEL = 2'b01,
        OP_DECEL = 2'b10,
        OP_CONST = 2'b11
    } op_state_type;
endpackage

// >>> avoid_if.sv
`timescale 1ns/1ps
interface avoid_if;
    logic [9:0]  voltage;
    logic [9:0]  prev_voltage;
    logic [2:0]  sensitivity;
    logic        decel;
    logic        rate_hit;
    logic [15:0] freq_cmd;
    logic [15:0] base_freq;
    logic [15:0] comp_freq;
    logic [15:0] limit;
    logic [15:0] max_freq;
    logic        hold;
    logic [15:0] limited;
    logic        over_limit;
    logic        release_ok;
    modport rate_mp (input voltage, prev_voltage, sensitivity, decel, output rate_hit);
    modport limit_mp (input freq_cmd, base_freq, comp_freq, limit, max_freq, hold,
                      output limited, over_limit, release_ok);
endinterface

// >>> rate_detect.sv
`timescale 1ns/1ps
module rate_detect
    import regen_pkg::*;
(
    avoid_if.rate_mp av
);
    logic [9:0]  th;
    logic [10:0] rise;

    always_comb
    begin
        // higher setting, smaller rise needed
        case (av.sensitivity)
            3'h1:    th = RATE_TH1;
            3'h2:    th = RATE_TH2;
            3'h3:    th = RATE_TH3;
            3'h4:    th = RATE_TH4;
            3'h5:    th = RATE_TH5;
            default: th = 10'h3ff;
        endcase
        rise = {1'b0, av.voltage} - {1'b0, av.prev_voltage};
    end

    // only falling-frequency phase, zero setting disables
    assign av.rate_hit = av.decel && (av.sensitivity != SENS_RST)
                         && !rise[10] && (rise[9:0] > th);
endmodule

// >>> freq_limit.sv
`timescale 1ns/1ps
module freq_limit
    import regen_pkg::*;
(
    avoid_if.limit_mp av
);
    logic [16:0] cap;
    logic [16:0] raised;
    logic [16:0] pick;
    logic        no_limit;

    always_comb
    begin
        cap      = {1'b0, av.base_freq} + {1'b0, av.limit};
        raised   = {1'b0, av.freq_cmd} + {1'b0, av.comp_freq};
        no_limit = (av.limit == LIMIT_OFF);
        // cap only applies once something has been added
        av.over_limit = !no_limit && (av.comp_freq != 16'h0000) && (raised > cap);
        if (av.hold || av.over_limit)
            pick = cap;
        else
            pick = raised;
        if (pick > {1'b0, av.max_freq})
            av.limited = av.max_freq;
        else
            av.limited = pick[15:0];
        av.release_ok = (av.freq_cmd <= {1'b0, av.limit[15:1]});
    end
endmodule

// >>> regen_avoidance_freq_comp.sv
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - raise frequency when bus at/above level
// - selections 1 and 2 enable; 1 always
// - selection 2 acts at constant speed only
// - selection resets to 0, meaning off
// - fast bus rise halts deceleration early
// - higher sensitivity needs smaller rise
// - sensitivity 0 off, 1 to 5 accepted
// - cap at prior frequency plus limit
// - decel overshoot holds limit until half
// - never exceed maximum frequency in selections 1 and 2; selection 0 passes the command through unclamped
// - limit code 9999 removes limit
// - limit accepts 0 to 10 Hz, reset 6
// - level accepts 300 to 800 V
// - gains 0 to 200 percent, reset 100
// - stall indication while avoidance acts
// - stall prevention on while avoidance acts
module regen_avoidance_freq_comp
    import regen_pkg::*;
#(
    parameter logic [9:0]  LEVEL_INIT = 10'h17c,
    parameter logic [15:0] MAXF_INIT  = 16'h0258
)
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // drive inputs
    input  wire logic [9:0]  bus_voltage,
    input  wire logic        sample_valid,
    input  wire logic [1:0]  op_state,
    input  wire logic [15:0] freq_cmd,
    // drive outputs
    output logic [15:0]      freq_out,
    output logic             decel_halt,
    output logic             stall_active_signal,
    output logic             ov_stall_display,
    output logic             stall_prevent_en,
    output logic             irq
);
    // settings
    logic [1:0]  mode_q;
    logic [9:0]  level_q;
    logic [2:0]  sens_q;
    logic [15:0] limit_q;
    logic [7:0]  vgain_q;
    logic [7:0]  fgain_q;
    logic [15:0] maxf_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    // bus slave state
    logic [7:0]  aw_addr_q;
    logic        aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_have_q;
    logic        wr_go;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;
    // control state
    logic [9:0]  prev_v_q;
    logic        active_q;
    logic        active_d;
    logic        rate_q;
    logic        hold_q;
    logic [15:0] base_q;
    logic [15:0] comp_q;
    logic [15:0] comp_d;
    logic        allowed;
    logic        at_level;
    logic [9:0]  excess;
    logic [9:0]  rise_pos;
    logic [18:0] vterm;
    logic [26:0] scaled;
    logic [15:0] inc;
    logic [16:0] comp_sum;
    logic [IRQ_W-1:0] irq_set;
    logic        decel;

    avoid_if av_bus();

    rate_detect u_rate
    (
        .av (av_bus.rate_mp)
    );

    freq_limit u_limit
    (
        .av (av_bus.limit_mp)
    );

    assign decel               = (op_state == OP_DECEL);
    assign av_bus.voltage      = bus_voltage;
    assign av_bus.prev_voltage = prev_v_q;
    assign av_bus.sensitivity  = sens_q;
    assign av_bus.decel        = decel;
    assign av_bus.freq_cmd     = freq_cmd;
    assign av_bus.base_freq    = base_q;
    assign av_bus.comp_freq    = comp_q;
    assign av_bus.limit        = limit_q;
    assign av_bus.max_freq     = maxf_q;
    assign av_bus.hold         = hold_q;

    // ---- axi4-lite write path
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            aw_have_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            if (wr_go)
                aw_have_q <= 1'b0;
            s_axi_awready <= !aw_have_q && !s_axi_awready ? 1'b1 : s_axi_awready && !wr_go;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            w_have_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            if (wr_go)
                w_have_q <= 1'b0;
            s_axi_wready <= !w_have_q && !s_axi_wready ? 1'b1 : s_axi_wready && !wr_go;
        end
    end

    always_comb
    begin
        case (aw_addr_q)
            OFS_MODE, OFS_LEVEL, OFS_SENS, OFS_LIMIT, OFS_VGAIN, OFS_FGAIN,
            OFS_MAXF, OFS_IRQ_CLR, OFS_IRQ_EN: wr_hit = 1'b1;
            default:                           wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // settings: out-of-range values are ignored, old value kept; maximum frequency and irq enable writes are not range checked
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mode_q  <= MODE_RST;
            level_q <= LEVEL_INIT;
            sens_q  <= SENS_RST;
            limit_q <= LIMIT_RST;
            vgain_q <= GAIN_RST;
            fgain_q <= GAIN_RST;
            maxf_q  <= MAXF_INIT;
            irq_en_q <= '0;
        end
        else if (wr_go && w_strb_q[0])
        begin
            case (aw_addr_q)
                OFS_MODE:
                    if (w_data_q[31:0] <= {30'h0, MODE_MAX})
                        mode_q <= w_data_q[1:0];
                OFS_LEVEL:
                    if (w_data_q[31:10] == 22'h0 && w_data_q[9:0] >= LEVEL_MIN
                        && w_data_q[9:0] <= LEVEL_MAX)
                        level_q <= w_data_q[9:0];
                OFS_SENS:
                    if (w_data_q[31:0] <= {29'h0, SENS_MAX})
                        sens_q <= w_data_q[2:0];
                OFS_LIMIT:
                    if (w_data_q[31:0] <= {16'h0, LIMIT_MAX}
                        || w_data_q[31:0] == {16'h0, LIMIT_OFF})
                        limit_q <= w_data_q[15:0];
                OFS_VGAIN:
                    if (w_data_q[31:0] <= {24'h0, GAIN_MAX})
                        vgain_q <= w_data_q[7:0];
                OFS_FGAIN:
                    if (w_data_q[31:0] <= {24'h0, GAIN_MAX})
                        fgain_q <= w_data_q[7:0];
                OFS_MAXF:
                    maxf_q <= w_data_q[15:0];
                OFS_IRQ_EN:
                    irq_en_q <= w_data_q[IRQ_W-1:0];
                default:
                    mode_q <= mode_q;
            endcase
        end
    end

    // ---- axi4-lite read path
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            OFS_MODE:     rd_word[1:0]  = mode_q;
            OFS_LEVEL:    rd_word[9:0]  = level_q;
            OFS_SENS:     rd_word[2:0]  = sens_q;
            OFS_LIMIT:    rd_word[15:0] = limit_q;
            OFS_VGAIN:    rd_word[7:0]  = vgain_q;
            OFS_FGAIN:    rd_word[7:0]  = fgain_q;
            OFS_MAXF:     rd_word[15:0] = maxf_q;
            OFS_STATE:    rd_word[3:0]  = {decel_halt, hold_q, rate_q, active_q};
            OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_q;
            OFS_IRQ_CLR:  rd_word = 32'h0000_0000;
            OFS_IRQ_EN:   rd_word[IRQ_W-1:0] = irq_en_q;
            OFS_COMP:     rd_word[15:0] = comp_q;
            default:      rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ---- avoidance decision and increment
    always_comb
    begin
        case (mode_q)
            2'h1:    allowed = 1'b1;
            2'h2:    allowed = (op_state == OP_CONST);
            default: allowed = 1'b0;
        endcase
        at_level = (bus_voltage >= level_q);
        excess   = at_level ? bus_voltage - level_q : 10'h000;
        rise_pos = (bus_voltage > prev_v_q) ? bus_voltage - prev_v_q : 10'h000;
        // gains in percent, product over 2^13 approximates the /10000
        vterm    = 19'(({9'h0, excess} + {9'h0, rise_pos}) * {11'h0, vgain_q});
        scaled   = 27'({8'h0, vterm} * {19'h0, fgain_q});
        inc      = 16'(scaled >> GAIN_SHIFT);
        active_d = allowed && (at_level || av_bus.rate_hit);
        comp_sum = {1'b0, comp_q} + {1'b0, inc};
        if (!allowed)
            comp_d = 16'h0000;
        else if (active_d && at_level)
            comp_d = comp_sum[16] ? 16'hffff : comp_sum[15:0];
        else if (comp_q > COMP_DECAY)
            comp_d = comp_q - COMP_DECAY;
        else
            comp_d = 16'h0000;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            prev_v_q <= 10'h000;
            active_q <= 1'b0;
            rate_q   <= 1'b0;
            comp_q   <= 16'h0000;
            base_q   <= 16'h0000;
        end
        else if (sample_valid)
        begin
            prev_v_q <= bus_voltage;
            active_q <= active_d;
            rate_q   <= allowed && av_bus.rate_hit;
            comp_q   <= comp_d;
            if (active_d && !active_q && comp_q == 16'h0000)
                base_q <= freq_cmd;
        end
    end

    // decel overshoot hold until command reaches half the limit
    always_ff @(posedge core_clk)
    begin
        if (srst)
            hold_q <= 1'b0;
        else if (!decel || mode_q == MODE_RST || av_bus.release_ok)
            hold_q <= 1'b0;
        else if (av_bus.over_limit && comp_q != 16'h0000)
            hold_q <= 1'b1;
    end

    // ---- outputs
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            freq_out   <= 16'h0000;
            decel_halt <= 1'b0;
        end
        else
        begin
            decel_halt <= rate_q && decel;
            if (mode_q == MODE_RST)
                freq_out <= freq_cmd;
            else if (rate_q && decel && freq_out > freq_cmd)
                freq_out <= freq_out;
            else
                freq_out <= av_bus.limited;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stall_active_signal <= 1'b0;
            ov_stall_display    <= 1'b0;
            stall_prevent_en    <= 1'b0;
        end
        else
        begin
            stall_active_signal <= active_q;
            ov_stall_display    <= active_q;
            stall_prevent_en    <= active_q;
        end
    end

    // ---- interrupts: set wins over clear
    assign irq_set = {hold_q, rate_q, active_q};

    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq_stat_q <= '0;
        else if (wr_go && w_strb_q[0] && aw_addr_q == OFS_IRQ_CLR)
            irq_stat_q <= (irq_stat_q & ~w_data_q[IRQ_W-1:0]) | irq_set;
        else
            irq_stat_q <= irq_stat_q | irq_set;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_q & irq_en_q);
    end
endmodule

// >>> regen_avoidance_freq_comp_asserts.sv
`timescale 1ns/1ps
module regen_avoidance_freq_comp_asserts
    import regen_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // drive side
    input wire logic        sample_valid,
    input wire logic [1:0]  op_state,
    input wire logic [15:0] freq_out,
    input wire logic        decel_halt,
    input wire logic        stall_active_signal,
    input wire logic        ov_stall_display,
    input wire logic        stall_prevent_en,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_reset_clears: assert property (
        $fell(srst) |-> freq_out == 16'h0000 && !stall_active_signal && !decel_halt && !irq)
        else $error("outputs not cleared by reset");
    a_stall_after_sample: assert property (
        $rose(stall_active_signal) |->
            $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("stall raised without a sample");
    a_halt_in_decel: assert property (
        $rose(decel_halt) |-> $past(op_state) == OP_DECEL
            || $past(op_state, 2) == OP_DECEL || $past(op_state, 3) == OP_DECEL)
        else $error("deceleration halt outside deceleration");
    a_display_match: assert property (
        ov_stall_display == stall_active_signal)
        else $error("stall display differs from stall signal");
    a_prevent_match: assert property (
        stall_prevent_en == stall_active_signal)
        else $error("stall prevention differs from stall signal");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule

// >>> regen_avoidance_freq_comp_tb.sv
`timescale 1ns/1ps
module regen_avoidance_freq_comp_tb
    import regen_pkg::*;
;
    typedef struct packed
    {
        logic [7:0]  a;
        logic [31:0] d;
        logic [1:0]  br;
        logic [31:0] rd;
        logic [1:0]  rr;
    } row_type;

    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sample_valid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [9:0]  bus_voltage = 10'h000;
    logic [1:0]  op_state = 2'h0;
    logic [15:0] freq_cmd = 16'h012c;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] freq_out;
    logic        decel_halt, stall_active_signal, ov_stall_display, stall_prevent_en, irq;
    int          mismatches = 0, cmp_count = 0;
    row_type     rows [17] = '{
        '{OFS_MODE, 32'h3, 2'h0, 32'h0, 2'h0},
        '{OFS_MODE, 32'h2, 2'h0, 32'h2, 2'h0},
        '{OFS_SENS, 32'h6, 2'h0, 32'h0, 2'h0},
        '{OFS_SENS, 32'h5, 2'h0, 32'h5, 2'h0},
        '{OFS_LIMIT, 32'h65, 2'h0, 32'h3c, 2'h0},
        '{OFS_LIMIT, 32'h270f, 2'h0, 32'h270f, 2'h0},
        '{OFS_LIMIT, 32'h64, 2'h0, 32'h64, 2'h0},
        '{OFS_LEVEL, 32'h12b, 2'h0, 32'h17c, 2'h0},
        '{OFS_LEVEL, 32'h321, 2'h0, 32'h17c, 2'h0},
        '{OFS_LEVEL, 32'h320, 2'h0, 32'h320, 2'h0},
        '{OFS_LEVEL, 32'h12c, 2'h0, 32'h12c, 2'h0},
        '{OFS_VGAIN, 32'hc9, 2'h0, 32'h64, 2'h0},
        '{OFS_VGAIN, 32'hc8, 2'h0, 32'hc8, 2'h0},
        '{OFS_FGAIN, 32'h0, 2'h0, 32'h0, 2'h0},
        '{OFS_MAXF, 32'h140, 2'h0, 32'h140, 2'h0},
        '{OFS_COMP, 32'h5, 2'h2, 32'h0, 2'h0},
        '{8'h30, 32'h1, 2'h2, 32'h0, 2'h2}
    };
    logic [7:0]  rst_a [8] = '{OFS_MODE, OFS_LEVEL, OFS_SENS, OFS_LIMIT,
                               OFS_VGAIN, OFS_FGAIN, OFS_MAXF, OFS_IRQ_EN};
    logic [31:0] rst_v [8] = '{32'h0, 32'h17c, 32'h0, 32'h3c, 32'h64, 32'h64, 32'h258, 32'h0};
    logic [2:0]  sens [3] = '{3'h0, 3'h1, 3'h5};

    regen_avoidance_freq_comp regen_avoidance_freq_comp_i (
        .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_voltage, .sample_valid,
        .op_state, .freq_cmd, .freq_out, .decel_halt, .stall_active_signal,
        .ov_stall_display, .stall_prevent_en, .irq
    );

    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic give_up();
        mismatches++;
        final_report();
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) give_up();
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) give_up();
    endtask

    // n control cycles at voltage v, then let outputs settle
    task automatic samp(input logic [9:0] v, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            bus_voltage <= v;
            sample_valid <= 1'b1;
            @(posedge core_clk);
            sample_valid <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
    endtask

    initial
    begin
        logic [1:0]  br;
        logic [1:0]  rr;
        logic [31:0] rd;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        foreach (rows[i])
        begin
            axi_write(rows[i].a, rows[i].d, br);
            check_val("bresp", rows[i].br, br);
            axi_read(rows[i].a, rd, rr);
            check_val("rresp", rows[i].rr, rr);
            check_val("rdata", rows[i].rd, rd);
        end
        $display("test register table done");
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        check_val("freq_out", 32'h0, freq_out);
        foreach (rst_a[i])
        begin
            axi_read(rst_a[i], rd, rr);
            check_val("reset value", rst_v[i], rd);
        end
        $display("test reset done");
        op_state <= OP_CONST;
        samp(10'h1f4, 3);
        check_val("freq_out", 32'h12c, freq_out);
        check_val("stall", 32'h0, stall_active_signal);
        axi_write(OFS_MODE, 32'h2, br);
        op_state <= OP_ACCEL;
        samp(10'h1f4, 3);
        check_val("freq_out", 32'h12c, freq_out);
        check_val("stall", 32'h0, stall_active_signal);
        $display("test no compensation done");
        axi_write(OFS_LIMIT, 32'ha, br);
        op_state <= OP_CONST;
        samp(10'h1f4, 4);
        check_val("freq_out", 32'h136, freq_out);
        check_val("stall", 32'h1, stall_active_signal);
        check_val("display", 32'h1, ov_stall_display);
        check_val("prevent", 32'h1, stall_prevent_en);
        check_val("irq masked", 32'h0, irq);
        axi_write(OFS_IRQ_EN, 32'h1, br);
        repeat (3) @(posedge core_clk);
        check_val("irq", 32'h1, irq);
        axi_read(OFS_IRQ_STAT, rd, rr);
        check_val("irq status", 32'h1, {31'h0, rd[IRQ_ACT]});
        axi_write(OFS_MODE, 32'h0, br);
        samp(10'h1f4, 1);
        check_val("freq_out", 32'h12c, freq_out);
        check_val("stall", 32'h0, stall_active_signal);
        axi_write(OFS_IRQ_CLR, 32'h7, br);
        repeat (3) @(posedge core_clk);
        check_val("irq cleared", 32'h0, irq);
        $display("test limit and irq done");
        axi_write(OFS_LIMIT, 32'h270f, br);
        axi_write(OFS_MAXF, 32'h140, br);
        axi_write(OFS_MODE, 32'h1, br);
        op_state <= OP_ACCEL;
        samp(10'h1f4, 4);
        check_val("freq_out", 32'h140, freq_out);
        axi_read(OFS_COMP, rd, rr);
        check_val("comp", 32'h248, rd);
        $display("test maximum clamp done");
        axi_write(OFS_LEVEL, 32'h320, br);
        op_state <= OP_DECEL;
        foreach (sens[i])
        begin
            axi_write(OFS_SENS, {29'h0, sens[i]}, br);
            samp(10'h190, 2);
            samp(10'h19a, 1);
            check_val("decel_halt", {31'h0, i == 2}, decel_halt);
        end
        $display("test rate detection done");
        axi_write(OFS_LIMIT, 32'h64, br);
        axi_read(OFS_STATE, rd, rr);
        check_val("hold", 32'h1, {31'h0, rd[2]});
        freq_cmd <= 16'h0032;
        axi_read(OFS_STATE, rd, rr);
        check_val("hold", 32'h0, {31'h0, rd[2]});
        $display("test limit hold done");
        final_report();
    end
endmodule

bind regen_avoidance_freq_comp regen_avoidance_freq_comp_asserts asserts_i (
    .core_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sample_valid, .op_state, .freq_out,
    .decel_halt, .stall_active_signal, .ov_stall_display, .stall_prevent_en, .irq
);
